// ==== osw_ctrl.sv ====
// Purpose: ON/OFF switcher control with AHB-Lite status and control registers
// Assumes: Comparator levels are synchronised here; one bus slave, OKAY only
// Notes: Gate drive and all bus outputs come straight from flip-flops
// How it works
// RULE1 - Supply below low threshold inhibits switching until high threshold reported
// RULE2 - Over-temperature indication inhibits switching until the cooled indication
// RULE3 - Current over limit ends the pulse for the rest of the cycle
// RULE4 - Current comparator ignored during blanking after each turn-on
// RULE5 - Current level steps down at lighter load, chosen from sample sequence
// RULE6 - Auto-restart counter advances per cycle, cleared on a low enable sample
// RULE7 - Fifty milliseconds without low enable gives 850 ms off, then retry
// RULE8 - Auto-restart keeps alternating until enable is pulled low again
// RULE9 - Line undervoltage during off period halts the counter and extends off
// RULE10 - After power-up or off period, switching starts only with line sense ok
// RULE11 - Supply held at low level while line undervoltage persists at power-up
// RULE12 - No sense resistor detected disables line undervoltage function
// RULE13 - Enabled cycle turns on at start, off on limit or duty end
// RULE14 - A started cycle always completes despite enable changes
// RULE15 - Clock runs always; enable sampled at each cycle start
// RULE16 - High sample gives full or reduced-threshold cycle by load
// RULE17 - Feedback holds enable high below reference, low above target
// RULE18 - At power-down switching runs 50 ms, then stays off while line low
// RULE19 - Supply charging enabled only while the switch is off
// RULE20 - Oscillator at 132 kHz gives cycle start and maximum-duty signals
// RULE21 - Enable reads low when over 240 uA is drawn
// RULE22 - Gate only with no inhibit active; comparators synchronised
// RULE23 - Auto-restart intervals are counts of oscillator cycles
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module osw_ctrl
	import osw_pkg::*;
#(
	parameter int unsigned AR_ON_CYC = AR_ON_OSC,
	parameter int unsigned AR_OFF_CYC = AR_OFF_OSC,
	parameter int unsigned BLANK_CYC = LEB_CYC
) (
	input wire logic hclk, // Clock, 200 MHz
	input wire logic hresetn, // Async reset, active low
	input wire logic ce, // Clock enable, freezes all state when low
	input wire osw_pkg::osw_cmp_s cmp, // Comparator levels
	input wire logic hsel, // AHB select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic hreadyout, // AHB slave ready
	output logic [31:0] hrdata, // AHB read data
	output logic hresp, // AHB response, always OKAY
	output logic gate_drive, // Power switch on
	output logic [1:0] current_level, // Active current threshold code
	output logic supply_charge_en, // Charge internal_supply_node
	output logic supply_hold_low, // Hold internal_supply_node at low level
	output logic restart_off // Auto-restart off period active
);
	typedef struct packed {
		logic on;
		logic [LEB_W-1:0] blank;
		logic prev_high;
		logic [1:0] skips;
		osw_lvl_e lvl;
		logic supply_lock;
		logic ot_lock;
		logic started;
		osw_ar_e ar;
		logic [ARC_W-1:0] arcnt;
		logic ctrl_run;
		logic ctrl_line;
		logic ap_wr;
		logic [3:0] ap_addr;
		logic ready;
		logic resp;
		logic [31:0] rdata;
		logic charge;
		logic hold_low;
	} osw_ctrl_s;

	osw_ctrl_s st_q;
	osw_ctrl_s st_d;
	osw_cmp_s cs;
	osw_osc_s osc;
	logic line_en;
	logic line_uv;
	logic inhibit;
	logic ap_take;
	logic [31:0] status_w;

	generate
		if (AR_ON_CYC < 2 || AR_OFF_CYC < 2 || AR_ON_CYC >= (1 << ARC_W) ||
			AR_OFF_CYC >= (1 << ARC_W) || BLANK_CYC < 1 || BLANK_CYC >= (1 << LEB_W))
		begin : g_chk
			$error("osw_ctrl count parameters out of range");
		end
	endgenerate

	// Comparator levels cross into the clock domain here
	osw_sync #(
		.W($bits(osw_cmp_s))
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.din(cmp),
		.dout(cs)
	); // RULE22

	osw_osc u_osc (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.osc(osc)
	); // RULE20

	// Line sensing is off when no resistor is fitted or software turned it off
	assign line_en = st_q.ctrl_line & ~cs.line_no_resistor; // RULE12
	assign line_uv = line_en & ~cs.line_above_start;
	assign inhibit = st_q.supply_lock | st_q.ot_lock | ~st_q.started |
		(st_q.ar == AR_OFF) | ~st_q.ctrl_run; // RULE22
	assign ap_take = hsel & hready & htrans[1];

	always_comb
	begin
		status_w = '0;
		status_w[ST_GATE_BIT] = st_q.on;
		status_w[ST_SUPPLY_BIT] = st_q.supply_lock;
		status_w[ST_OT_BIT] = st_q.ot_lock;
		status_w[ST_STARTED_BIT] = st_q.started;
		status_w[ST_AROFF_BIT] = st_q.ar == AR_OFF;
		status_w[ST_LINEUV_BIT] = line_uv;
		status_w[ST_LINEEN_BIT] = line_en;
		status_w[ST_LVL_LSB +: 2] = st_q.lvl;
	end

	always_comb
	begin
		st_d = st_q;
		if (ce)
		begin
			// Set wins over clear on both protection latches
			if (cs.supply_below_low)
				st_d.supply_lock = 1'b1; // RULE1
			else if (cs.supply_at_high)
				st_d.supply_lock = 1'b0; // RULE1
			if (cs.overtemp_hot)
				st_d.ot_lock = 1'b1; // RULE2
			else if (cs.overtemp_cooled)
				st_d.ot_lock = 1'b0; // RULE2

			// Once running, line undervoltage no longer stops switching
			if (!st_q.started && st_q.ar == AR_RUN && !line_uv && !st_q.supply_lock)
				st_d.started = 1'b1; // RULE10 RULE18

			// Pulse within a cycle; enable is not looked at here
			if (st_q.blank != '0)
				st_d.blank = st_q.blank - LEB_W'(1);
			if (st_q.on && ((cs.current_over_limit && st_q.blank == '0) ||
				!osc.max_duty_signal || inhibit))
				st_d.on = 1'b0; // RULE3 RULE4 RULE13 RULE14

			if (osc.cycle_start)
			begin
				// Enable high means under 240 uA drawn; low ends the request
				st_d.prev_high = cs.enable_linesense_input; // RULE15 RULE21
				if (cs.enable_linesense_input && !inhibit)
				begin
					st_d.on = 1'b1; // RULE13 RULE16
					st_d.blank = LEB_W'(BLANK_CYC); // RULE4
				end
				else
					st_d.on = 1'b0;

				// Steps up on back-to-back requests, down after several skips
				if (cs.enable_linesense_input)
				begin
					st_d.skips = '0;
					if (st_q.prev_high)
					begin
						unique case (st_q.lvl)
							LVL_LOW: st_d.lvl = LVL_MED; // RULE5
							LVL_MED: st_d.lvl = LVL_FULL; // RULE5
							LVL_FULL: st_d.lvl = LVL_FULL;
							default: st_d.lvl = LVL_FULL;
						endcase
					end
				end
				else if (st_q.skips == 2'(SKIP_STEP - 1))
				begin
					st_d.skips = '0;
					unique case (st_q.lvl)
						LVL_FULL: st_d.lvl = LVL_MED; // RULE5
						LVL_MED: st_d.lvl = LVL_LOW; // RULE5
						LVL_LOW: st_d.lvl = LVL_LOW;
						default: st_d.lvl = LVL_FULL;
					endcase
				end
				else
					st_d.skips = st_q.skips + 2'(1);

				// Counts are in oscillator cycles, not hclk cycles
				unique case (st_q.ar)
					AR_RUN:
					begin
						if (!cs.enable_linesense_input)
							st_d.arcnt = '0; // RULE6 RULE8
						else if (st_q.arcnt == ARC_W'(AR_ON_CYC - 1))
						begin
							st_d.arcnt = '0;
							st_d.ar = AR_OFF; // RULE7 RULE18
							st_d.started = 1'b0; // RULE10
							st_d.on = 1'b0;
						end
						else
							st_d.arcnt = st_q.arcnt + ARC_W'(1); // RULE6 RULE23
					end
					AR_OFF:
					begin
						if (line_uv)
							st_d.arcnt = st_q.arcnt; // RULE9
						else if (st_q.arcnt >= ARC_W'(AR_OFF_CYC - 1))
						begin
							st_d.arcnt = '0;
							st_d.ar = AR_RUN; // RULE7 RULE8
						end
						else
							st_d.arcnt = st_q.arcnt + ARC_W'(1); // RULE23
					end
					default: st_d.ar = AR_RUN;
				endcase
			end

			st_d.charge = ~st_d.on; // RULE19
			st_d.hold_low = ~st_d.started & line_uv; // RULE11

			// Bus: zero wait states, read data formed in the address phase
			st_d.ready = 1'b1;
			st_d.resp = 1'b0;
			if (st_q.ap_wr && st_q.ap_addr == ADDR_CTRL)
			begin
				st_d.ctrl_run = hwdata[CTRL_RUN_BIT];
				st_d.ctrl_line = hwdata[CTRL_LINE_BIT];
			end
			st_d.ap_wr = 1'b0;
			if (ap_take)
			begin
				st_d.ap_wr = hwrite && haddr[31:4] == '0;
				st_d.ap_addr = {haddr[3:2], 2'b00};
				st_d.rdata = '0;
				if (!hwrite && haddr[31:4] == '0)
				begin
					unique case ({haddr[3:2], 2'b00})
						ADDR_CTRL: st_d.rdata = {30'h0, st_q.ctrl_line, st_q.ctrl_run};
						ADDR_STATUS: st_d.rdata = status_w;
						ADDR_ARCNT: st_d.rdata = {{(32 - ARC_W){1'b0}}, st_q.arcnt};
						default: st_d.rdata = '0;
					endcase
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q <= '0;
			st_q.lvl <= LVL_FULL;
			st_q.supply_lock <= 1'b1;
			st_q.ar <= AR_RUN;
			st_q.ctrl_run <= CTRL_RESET[CTRL_RUN_BIT];
			st_q.ctrl_line <= CTRL_RESET[CTRL_LINE_BIT];
			st_q.ready <= 1'b1;
			st_q.charge <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	assign hreadyout = st_q.ready;
	assign hresp = st_q.resp;
	assign hrdata = st_q.rdata;
	assign gate_drive = st_q.on;
	assign current_level = st_q.lvl;
	assign supply_charge_en = st_q.charge;
	assign supply_hold_low = st_q.hold_low;
	assign restart_off = st_q.ar == AR_OFF;
endmodule

// ==== osw_pkg.sv ====
// Purpose: Shared constants and types for the ON/OFF switcher controller
// Assumes: hclk at 200 MHz; comparator inputs already digital levels
// Notes: All times are kept in their own unit; cycle counts derive from them
package osw_pkg;

	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned OSC_HZ = 132_000;
	localparam int unsigned OSC_PERIOD_CYC = CLK_HZ / OSC_HZ;
	localparam int unsigned MAX_DUTY_PCT = 65;
	localparam int unsigned MAX_DUTY_CYC = OSC_PERIOD_CYC * MAX_DUTY_PCT / 100;
	localparam int unsigned LEB_NS = 200;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned LEB_CYC = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned AR_ON_MS = 50;
	localparam int unsigned AR_OFF_MS = 850;
	localparam int unsigned AR_ON_OSC = OSC_HZ / 1000 * AR_ON_MS;
	localparam int unsigned AR_OFF_OSC = OSC_HZ / 1000 * AR_OFF_MS;
	localparam int unsigned SKIP_STEP = 3;

	localparam int unsigned OSC_W = 11;
	localparam int unsigned LEB_W = 8;
	localparam int unsigned ARC_W = 17;

	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_ARCNT = 4'h8;
	localparam logic [1:0] CTRL_RESET = 2'h3;
	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam int unsigned CTRL_LINE_BIT = 1;
	localparam int unsigned ST_GATE_BIT = 0;
	localparam int unsigned ST_SUPPLY_BIT = 1;
	localparam int unsigned ST_OT_BIT = 2;
	localparam int unsigned ST_STARTED_BIT = 3;
	localparam int unsigned ST_AROFF_BIT = 4;
	localparam int unsigned ST_LINEUV_BIT = 5;
	localparam int unsigned ST_LINEEN_BIT = 6;
	localparam int unsigned ST_LVL_LSB = 8;

	typedef enum logic [1:0] {LVL_LOW = 2'b00, LVL_MED = 2'b01, LVL_FULL = 2'b10} osw_lvl_e;
	typedef enum logic {AR_RUN = 1'b0, AR_OFF = 1'b1} osw_ar_e;

	typedef struct packed {
		logic supply_below_low;
		logic supply_at_high;
		logic overtemp_hot;
		logic overtemp_cooled;
		logic current_over_limit;
		logic enable_linesense_input;
		logic line_above_start;
		logic line_no_resistor;
	} osw_cmp_s;

	typedef struct packed {
		logic cycle_start;
		logic max_duty_signal;
	} osw_osc_s;

endpackage

// ==== osw_sync.sv ====
// Purpose: Two-flop synchroniser for a group of comparator levels
// Assumes: Inputs are slow levels; single-bit glitches are tolerated
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module osw_sync #(
	parameter int unsigned W = 8
) (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic [W-1:0] din, // Raw levels
	output logic [W-1:0] dout // Synchronised levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} osw_sync_s;

	osw_sync_s st_q;
	osw_sync_s st_d;

	generate
		if (W < 1)
		begin : g_chk
			$error("osw_sync width must be at least one");
		end
	endgenerate

	always_comb
	begin
		st_d = st_q;
		if (ce)
		begin
			st_d.s1 = din;
			st_d.s2 = st_q.s1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign dout = st_q.s2;
endmodule

// ==== osw_osc.sv ====
// Purpose: Free-running oscillator giving cycle start and maximum-duty window
// Assumes: Period and duty given in hclk cycles
// Notes: No jitter; the average rate is the fixed period
`timescale 1ns/1ps
module osw_osc
	import osw_pkg::*;
#(
	parameter int unsigned PERIOD_CYC = OSC_PERIOD_CYC,
	parameter int unsigned DUTY_CYC = MAX_DUTY_CYC
) (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Async reset, active low
	input wire logic ce, // Clock enable
	output osw_pkg::osw_osc_s osc // Cycle start pulse and duty window
);
	typedef struct packed {
		logic [OSC_W-1:0] cnt;
		osw_osc_s o;
	} osw_osc_st_s;

	osw_osc_st_s st_q;
	osw_osc_st_s st_d;

	generate
		if (PERIOD_CYC < 4 || PERIOD_CYC > (1 << OSC_W) || DUTY_CYC < 1 || DUTY_CYC >= PERIOD_CYC)
		begin : g_chk
			$error("osw_osc period or duty out of range");
		end
	endgenerate

	always_comb
	begin
		st_d = st_q;
		if (ce)
		begin
			st_d.o.cycle_start = 1'b0;
			if (st_q.cnt == OSC_W'(PERIOD_CYC - 1))
			begin
				st_d.cnt = '0;
				st_d.o.cycle_start = 1'b1;
				st_d.o.max_duty_signal = 1'b1;
			end
			else
			begin
				st_d.cnt = st_q.cnt + OSC_W'(1);
				if (st_q.cnt == OSC_W'(DUTY_CYC - 1))
					st_d.o.max_duty_signal = 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign osc = st_q.o;
endmodule

// ==== osw_ctrl_props.sv ====
// Purpose: Concurrent checks on the switcher controller ports
// Assumes: One clock domain; counts shortened by parameters
// Notes: Helper counters measure on, off and restart-off run lengths
`timescale 1ns/1ps
module osw_ctrl_props
	import osw_pkg::*;
#(
	parameter int unsigned AR_ON_CYC = AR_ON_OSC,
	parameter int unsigned AR_OFF_CYC = AR_OFF_OSC,
	parameter int unsigned BLANK_CYC = LEB_CYC
) (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Async reset, active low
	input wire osw_pkg::osw_cmp_s cmp, // Comparator levels
	input wire logic gate_drive, // Switch on
	input wire logic [1:0] current_level, // Threshold code
	input wire logic supply_charge_en, // Supply charging
	input wire logic supply_hold_low, // Supply held low
	input wire logic restart_off // Off period
);
	localparam int MIN_OFF = OSC_PERIOD_CYC - MAX_DUTY_CYC - 2;
	localparam int AR_MIN = (AR_OFF_CYC - 1) * OSC_PERIOD_CYC;
	typedef struct packed {
		logic [11:0] on;
		logic [11:0] off;
		logic [19:0] ro;
	} osw_chk_s;
	osw_chk_s st_q, st_d;
	always_comb
	begin
		st_d = st_q;
		st_d.on = gate_drive ? st_q.on + 12'h001 : 12'h000;
		// Saturate so a long idle never wraps to a short one
		st_d.off = gate_drive ? 12'h000 : st_q.off + {11'h000, st_q.off != 12'hFFF};
		st_d.ro = restart_off ? st_q.ro + 20'h00001 : 20'h00000;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_q <= {12'h000, 12'hFFF, 20'h00000};
		else
			st_q <= st_d;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_supply_low;
		cmp.supply_below_low[*6];
	endsequence
	sequence s_hot;
		cmp.overtemp_hot[*6];
	endsequence
	sequence s_limit_late;
		(gate_drive && cmp.current_over_limit && st_q.on > BLANK_CYC + 4)[*3];
	endsequence
	AST_CHARGE_OFF: assert property (supply_charge_en == !gate_drive)
		else $error("supply charging while switch on");
	AST_SUPPLY_INHIBIT: assert property (s_supply_low |-> !gate_drive)
		else $error("switching during supply lock");
	AST_OT_INHIBIT: assert property (s_hot |-> !gate_drive)
		else $error("switching while hot");
	AST_LIMIT_ENDS: assert property (s_limit_late |=> !gate_drive)
		else $error("pulse not ended on current limit");
	AST_BLANK_HOLD: assert property (($rose(gate_drive) ##1
		(!cmp.supply_below_low && !cmp.overtemp_hot)[*5]) |-> gate_drive)
		else $error("pulse ended inside blanking");
	AST_DUTY_LIMIT: assert property (gate_drive |-> st_q.on < MAX_DUTY_CYC)
		else $error("pulse beyond maximum duty");
	AST_ONE_PER_CYCLE: assert property ($rose(gate_drive) |-> st_q.off >= MIN_OFF)
		else $error("second pulse inside one cycle");
	AST_RESTART_NO_GATE: assert property (restart_off ##1 restart_off |-> !gate_drive)
		else $error("switching in restart off period");
	AST_RESTART_LEN: assert property ($fell(restart_off) |-> st_q.ro >= AR_MIN)
		else $error("restart off period too short");
	AST_HOLD_NO_GATE: assert property (supply_hold_low |-> !gate_drive)
		else $error("switching before line start");
	AST_LEVEL_STEP: assert property ($changed(current_level) |-> current_level != 2'h3 &&
		(current_level == $past(current_level) + 2'h1 ||
		current_level == $past(current_level) - 2'h1))
		else $error("current level jumped");
endmodule

// ==== osw_fb_model.sv ====
// Purpose: Feedback optocoupler and power stage seen by the controller
// Assumes: Switch current ramps linearly while the gate is on
// Notes: Ramp of zero gives a turn-on spike above the limit
`timescale 1ns/1ps
module osw_fb_model (
	input wire logic hclk, // Clock
	input wire logic gate_drive, // Switch on
	input wire logic request, // Output below its reference
	input wire logic [11:0] ramp_cyc, // Clocks until current reaches limit
	output logic enable_linesense_input = 1'b1, // Feedback level
	output logic current_over_limit = 1'b0 // Current above threshold
);
	logic [11:0] on_q = 12'h000;
	always_ff @(posedge hclk)
	begin
		on_q <= gate_drive ? on_q + 12'h001 : 12'h000;
		current_over_limit <= gate_drive && on_q >= ramp_cyc;
		enable_linesense_input <= request;
	end
endmodule

// ==== test_onoff_switcher_controller.sv ====
// Purpose: Self-checking bench for the switcher controller
// Assumes: Shortened restart and blanking counts
// Notes: Bus tasks wait on hreadyout; a cycle ceiling ends a hang
`timescale 1ns/1ps
module test_onoff_switcher_controller;
	import osw_pkg::*;
	localparam int PER = OSC_PERIOD_CYC;
	localparam int ARN = 8;
	localparam int ARF = 6;
	localparam int BLK = 10;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic req = 1'b1;
	logic s_low = 1'b0, s_high = 1'b0, hot = 1'b0, cool = 1'b0, line_ok = 1'b0, no_res = 1'b0;
	logic [11:0] ramp = 12'hFFF;
	logic hreadyout, hresp, gate_drive, supply_charge_en, supply_hold_low, restart_off, lim, en;
	logic [1:0] current_level;
	logic [31:0] hrdata, rd;
	osw_cmp_s cmp;
	int fail_count = 0, checked = 0, cycles = 0, w, n;
	assign cmp = {s_low, s_high, hot, cool, lim, en, line_ok, no_res};
	osw_ctrl #(.AR_ON_CYC(ARN), .AR_OFF_CYC(ARF), .BLANK_CYC(BLK)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .cmp(cmp), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .gate_drive(gate_drive),
		.current_level(current_level), .supply_charge_en(supply_charge_en),
		.supply_hold_low(supply_hold_low), .restart_off(restart_off));
	osw_fb_model u_fb (.hclk(hclk), .gate_drive(gate_drive), .request(req), .ramp_cyc(ramp),
		.enable_linesense_input(en), .current_over_limit(lim));
	initial
	begin
		forever #2.5 hclk = ~hclk;
	end
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 99000)
		begin
			fail_count++;
			$display("[FAIL] run length expected below 99000 seen %0d", cycles);
			conclude();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic rng(input string what, input int lo, input int hi, input int got);
		checked++;
		if (got < lo || got > hi)
		begin
			fail_count++;
			$display("[FAIL] %s expected %0d to %0d seen %0d", what, lo, hi, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {28'h0000000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Optional drop of the request just after turn-on, to prove the cycle completes
	task automatic pulse(input logic drop);
		n = 0;
		w = 0;
		while (gate_drive !== 1'b1 && n < 2 * PER)
		begin
			@(negedge hclk);
			n++;
		end
		while (gate_drive === 1'b1)
		begin
			w++;
			if (drop && w == 1)
				@(posedge hclk) req <= 1'b0;
			@(negedge hclk);
		end
	endtask
	task automatic no_pulse(input int k);
		n = 0;
		repeat (k * PER)
		begin
			@(negedge hclk);
			n += int'(gate_drive !== 1'b0);
		end
		chk("gate high samples", 32'h0, n);
	endtask
	task automatic wait_ro(input logic v);
		n = 0;
		while (restart_off !== v && n < 16 * PER)
		begin
			@(negedge hclk);
			n++;
		end
	endtask
	// One low sample clears the restart count between tests
	task automatic fb_low();
		@(posedge hclk) req <= 1'b0;
		repeat (PER) @(posedge hclk);
	endtask
	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(negedge hclk);
		// Line sense is on with no start level yet, so the supply is held low
		chk("reset outputs", {6'h26, LVL_FULL}, {hreadyout, hresp, gate_drive,
			supply_charge_en, supply_hold_low, restart_off, current_level});
		$display("reset test done");
		@(posedge hclk) s_high <= 1'b1;
		no_pulse(1);
		@(posedge hclk) line_ok <= 1'b1;
		pulse(1'b0);
		rng("duty width", MAX_DUTY_CYC - 2, MAX_DUTY_CYC, w);
		chk("hold low", 32'h0, supply_hold_low);
		$display("power-up test done");
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", {30'h0, CTRL_RESET}, rd);
		bus(1'b1, ADDR_CTRL, 32'h0);
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", 32'h0, rd);
		no_pulse(1);
		bus(1'b1, ADDR_CTRL, {30'h0, CTRL_RESET});
		bus(1'b0, 4'hC, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("register test done");
		pulse(1'b1);
		rng("width after drop", MAX_DUTY_CYC - 2, MAX_DUTY_CYC, w);
		no_pulse(1);
		repeat (3 * PER) @(negedge hclk);
		chk("level", LVL_MED, current_level);
		repeat (4 * PER) @(negedge hclk);
		chk("level", LVL_LOW, current_level);
		@(posedge hclk) req <= 1'b1;
		repeat (2 * PER) @(negedge hclk);
		chk("level", LVL_MED, current_level);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk("status", {LVL_MED, 1'b1}, {rd[ST_LVL_LSB +: 2], rd[ST_STARTED_BIT]});
		$display("level test done");
		@(posedge hclk) ramp <= 12'h064;
		pulse(1'b0);
		rng("limit width", 100, 106, w);
		@(posedge hclk) ramp <= 12'h000;
		pulse(1'b0);
		rng("blank width", BLK, BLK + 6, w);
		@(posedge hclk) ramp <= 12'h064;
		$display("limit test done");
		fb_low();
		s_high <= 1'b0;
		s_low <= 1'b1;
		req <= 1'b1;
		no_pulse(1);
		@(posedge hclk) s_low <= 1'b0;
		no_pulse(1);
		@(posedge hclk) s_high <= 1'b1;
		pulse(1'b0);
		rng("pulse after supply", 100, 106, w);
		fb_low();
		hot <= 1'b1;
		req <= 1'b1;
		no_pulse(1);
		@(posedge hclk) hot <= 1'b0;
		no_pulse(1);
		@(posedge hclk) cool <= 1'b1;
		pulse(1'b0);
		rng("pulse after cooling", 100, 106, w);
		$display("inhibit test done");
		fb_low();
		req <= 1'b1;
		wait_ro(1'b1);
		rng("restart onset", (ARN - 1) * PER, (ARN + 2) * PER, n);
		repeat (3 * PER) @(posedge hclk);
		line_ok <= 1'b0;
		repeat (4 * PER) @(negedge hclk);
		chk("off held", 32'h1, restart_off);
		@(posedge hclk) line_ok <= 1'b1;
		wait_ro(1'b0);
		rng("off release", 2 * PER, 4 * PER, n);
		pulse(1'b0);
		rng("pulse after off", 100, 106, w);
		wait_ro(1'b1);
		@(posedge hclk) line_ok <= 1'b0;
		no_res <= 1'b1;
		wait_ro(1'b0);
		rng("off length", (ARF - 1) * PER, (ARF + 1) * PER, n);
		$display("restart test done");
		conclude();
	end
endmodule
bind osw_ctrl osw_ctrl_props #(.AR_ON_CYC(AR_ON_CYC), .AR_OFF_CYC(AR_OFF_CYC),
	.BLANK_CYC(BLANK_CYC)) u_props (.hclk(hclk), .hresetn(hresetn), .cmp(cmp),
	.gate_drive(gate_drive), .current_level(current_level), .supply_charge_en(supply_charge_en),
	.supply_hold_low(supply_hold_low), .restart_off(restart_off));
